/* rtl/dmabi_regs.vh */
`ifndef DMABI_REGS_VH
`define DMABI_REGS_VH
// ---------------------------------------------------------------
// Register indices on the low address nibble
// ---------------------------------------------------------------
`define DMABI_REG_ADDR0   4'h0
`define DMABI_REG_COUNT0  4'h1
`define DMABI_REG_ADDR1   4'h2
`define DMABI_REG_COUNT1  4'h3
`define DMABI_REG_ADDR2   4'h4
`define DMABI_REG_COUNT2  4'h5
`define DMABI_REG_ADDR3   4'h6
`define DMABI_REG_COUNT3  4'h7
`define DMABI_REG_CMD     4'h8
`define DMABI_REG_STATUS  4'h8
`define DMABI_REG_REQ     4'h9
`define DMABI_REG_MASK    4'hA
`define DMABI_REG_MODE    4'hB
`define DMABI_REG_TEMP    4'hD
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define DMABI_CMD_M2M     0
`define DMABI_CMD_DISABLE 2
`define DMABI_MODE_DIR    2
`define DMABI_REQ_SET     2
// ---------------------------------------------------------------
// Reset values and FIFO size
// ---------------------------------------------------------------
`define DMABI_CMD_RST     8'h00
`define DMABI_STAT_RST    8'h00
`define DMABI_MASK_RST    4'hF
`define DMABI_BYTE_RST    8'h00
`define DMABI_FIFO_DEPTH  16
`define DMABI_FIFO_AW     4
`endif

/* rtl/dmabi_fifo.v */
// ---------------------------------------------------------------
// Small synchronous FIFO, registered read data
// ---------------------------------------------------------------
module dmabi_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             i_clk_sys,
  input  wire             i_rst,
  input  wire             i_ce,
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  output reg              o_out_valid,
  input  wire             i_out_ready,
  output reg  [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  reg [AW:0]      cnt_ff;
  wire            push;
  wire            pop;
  wire            stored;

  // Output register is not counted; ready drops when DEPTH entries are stored
  assign stored     = (cnt_ff != {(AW+1){1'b0}});
  assign o_in_ready = (cnt_ff != DEPTH[AW:0]);
  assign push       = i_in_valid & o_in_ready;
  assign pop        = stored & (~o_out_valid | i_out_ready);

  // Storage array, no reset needed
  always @(posedge i_clk_sys) begin
    if (i_ce && push) begin
      mem_ff[wr_ptr_ff] <= i_in_data;
    end
  end

  // Pointers, count and output stage
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_ff   <= {AW{1'b0}};
      rd_ptr_ff   <= {AW{1'b0}};
      cnt_ff      <= {(AW+1){1'b0}};
      o_out_valid <= 1'b0;
      o_out_data  <= {WIDTH{1'b0}};
    end else if (i_ce) begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_ff  <= rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
        o_out_data <= mem_ff[rd_ptr_ff];
      end
      if (pop) begin
        o_out_valid <= 1'b1;
      end else if (i_out_ready) begin
        o_out_valid <= 1'b0;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // dmabi_fifo

/* rtl/dmabi_sync.v */
// ---------------------------------------------------------------
// Three-stage pin synchroniser; change taken when stages 2,3 agree
// ---------------------------------------------------------------
module dmabi_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input  wire         i_clk_sys,
  input  wire         i_rst,
  input  wire         i_ce,
  input  wire [W-1:0] i_pin,
  output reg  [W-1:0] o_level
);
  reg [W-1:0] s1_ff;
  reg [W-1:0] s2_ff;
  reg [W-1:0] s3_ff;
  integer     k;

  // Stage 1 only feeds stage 2; filter looks at 2 and 3
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      s1_ff   <= INIT;
      s2_ff   <= INIT;
      s3_ff   <= INIT;
      o_level <= INIT;
    end else if (i_ce) begin
      s1_ff <= i_pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (k = 0; k < W; k = k + 1) begin
        if (s2_ff[k] == s3_ff[k]) begin
          o_level[k] <= s3_ff[k];
        end
      end
    end
  end
endmodule // dmabi_sync

/* rtl/dmabi_core.v */
`include "dmabi_regs.vh"
module dmabi_core (
  input  wire       i_clk_sys,
  input  wire       i_rst,
  input  wire       i_ce,
  input  wire       i_chip_select_n,
  input  wire       i_ready_n,
  input  wire       i_bus_hold_grant,
  input  wire [3:0] i_channel_request,
  output reg        o_bus_hold_request,
  output reg  [3:0] o_channel_grant_n,
  output reg        o_upper_address_gate,
  output reg        o_upper_address_strobe,
  output reg        o_memory_read_strobe_n,
  output reg        o_memory_write_strobe_n,
  input  wire [7:0] i_data_bus_lines,
  output reg  [7:0] o_data_bus_lines,
  output reg        o_data_bus_lines_oe,
  input  wire       i_io_read_strobe_n,
  output reg        o_io_read_strobe_n,
  output reg        o_io_read_strobe_n_oe,
  input  wire       i_io_write_strobe_n,
  output reg        o_io_write_strobe_n,
  output reg        o_io_write_strobe_n_oe,
  input  wire       i_end_of_process_n,
  output reg        o_end_of_process_n,
  output reg        o_end_of_process_n_oe,
  input  wire [3:0] i_low_address_nibble,
  output reg  [3:0] o_low_address_nibble,
  output reg        o_low_address_nibble_oe,
  output reg  [3:0] o_high_address_nibble,
  output reg        o_high_address_nibble_oe,
  output reg  [7:0] o_mem_data,
  output reg        o_mem_data_valid,
  output reg        o_busy
);
  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_HOLD = 6'h02;
  localparam [5:0] ST_ADDR = 6'h04;
  localparam [5:0] ST_XFER = 6'h08;
  localparam [5:0] ST_WAIT = 6'h10;
  localparam [5:0] ST_DONE = 6'h20;

  reg  [5:0]  state_ff;
  reg  [5:0]  nxt_state;
  reg  [7:0]  cmd_ff;
  reg  [7:0]  status_ff;
  reg  [3:0]  req_ff;
  reg  [3:0]  mask_ff;
  reg  [3:0]  dir_ff;
  reg  [7:0]  temp_ff;
  reg  [15:0] addr_ff [0:3];
  reg  [15:0] count_ff [0:3];
  reg  [1:0]  chan_ff;
  reg  [15:0] cur_addr_ff;
  reg         rd_seen_ff;
  reg         wr_seen_ff;
  reg  [7:0]  rd_data;
  reg  [1:0]  nxt_chan;
  reg         any_pend;
  wire [3:0]  req_s;
  wire        cs_s;
  wire        rdy_s;
  wire        bus_hold_grant_s;
  wire        eop_s;
  wire        ior_s;
  wire        iow_s;
  wire        idle_sel;
  wire        wr_stb;
  wire [3:0]  pend;
  wire        is_m2m;
  wire        cur_dir;
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [7:0]  fifo_out_data;
  wire [15:0] nxt_addr;
  integer     i;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  dmabi_sync #(.W(10), .INIT(10'h027)) u_sync ( // Idle pin levels
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_ce      (i_ce),
    .i_pin     ({i_channel_request, i_chip_select_n, i_ready_n,
                 i_bus_hold_grant, i_end_of_process_n,
                 i_io_read_strobe_n, i_io_write_strobe_n}),
    .o_level   ({req_s, cs_s, rdy_s, bus_hold_grant_s, eop_s, ior_s, iow_s})
  );

  // Transfer data buffered before presenting to user side
  dmabi_fifo #(.WIDTH(8), .DEPTH(`DMABI_FIFO_DEPTH),
               .AW(`DMABI_FIFO_AW)) u_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (i_rst),
    .i_ce        (i_ce),
    .i_in_valid  (state_ff == ST_XFER && !rdy_s),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (i_data_bus_lines),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (1'b1),
    .o_out_data  (fifo_out_data)
  );

  // ---------------------------------------------------------------
  // Decode and arbitration
  // ---------------------------------------------------------------
  assign idle_sel = (state_ff == ST_IDLE) && !cs_s;
  assign wr_stb   = idle_sel && !iow_s;
  assign pend     = (req_s | req_ff) & ~mask_ff;
  assign is_m2m   = cmd_ff[`DMABI_CMD_M2M];
  assign cur_dir  = dir_ff[chan_ff];
  assign nxt_addr = (state_ff == ST_HOLD) ? addr_ff[nxt_chan] : // Stepped
                    cur_addr_ff + 16'h0001;

  // Lowest channel wins
  always @* begin
    nxt_chan = 2'd0;
    any_pend = |pend & ~cmd_ff[`DMABI_CMD_DISABLE];
    if (pend[0]) begin
      nxt_chan = 2'd0;
    end else if (pend[1]) begin
      nxt_chan = 2'd1;
    end else if (pend[2]) begin
      nxt_chan = 2'd2;
    end else begin
      nxt_chan = 2'd3;
    end
  end

  // Register readback mux
  always @* begin
    rd_data = `DMABI_BYTE_RST;
    case (i_low_address_nibble)
      `DMABI_REG_STATUS: rd_data = status_ff;
      `DMABI_REG_TEMP:   rd_data = temp_ff;
      `DMABI_REG_MASK:   rd_data = {4'h0, mask_ff};
      default: begin
        if (!i_low_address_nibble[3]) begin
          rd_data = i_low_address_nibble[0] ?
                    count_ff[i_low_address_nibble[2:1]][7:0] :
                    addr_ff[i_low_address_nibble[2:1]][7:0];
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: if (any_pend) nxt_state = ST_HOLD;
      ST_HOLD: begin
        if (!any_pend) nxt_state = ST_DONE;
        else if (bus_hold_grant_s) nxt_state = ST_ADDR;
      end
      ST_ADDR: nxt_state = ST_XFER;
      ST_XFER: begin
        if (!eop_s) nxt_state = ST_DONE;
        else if (rdy_s || !fifo_in_ready) nxt_state = ST_WAIT;
        else if (count_ff[chan_ff] == 16'h0000) nxt_state = ST_DONE;
        else nxt_state = ST_ADDR;
      end
      ST_WAIT: begin
        if (!eop_s) nxt_state = ST_DONE;
        else if (!rdy_s && fifo_in_ready) nxt_state = ST_XFER;
      end
      ST_DONE: if (!bus_hold_grant_s) nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // State, registers and pin drivers
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_ff                 <= ST_IDLE;
      cmd_ff                   <= `DMABI_CMD_RST;
      status_ff                <= `DMABI_STAT_RST;
      req_ff                   <= 4'h0;
      temp_ff                  <= `DMABI_BYTE_RST;
      mask_ff                  <= `DMABI_MASK_RST;
      dir_ff                   <= 4'h0;
      chan_ff                  <= 2'd0;
      cur_addr_ff              <= 16'h0000;
      rd_seen_ff               <= 1'b0;
      wr_seen_ff               <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
        addr_ff[i]  <= 16'h0000;
        count_ff[i] <= 16'h0000;
      end
      o_bus_hold_request       <= 1'b0;
      o_channel_grant_n        <= 4'hF;
      o_upper_address_gate     <= 1'b0;
      o_upper_address_strobe   <= 1'b0;
      o_memory_read_strobe_n   <= 1'b1;
      o_memory_write_strobe_n  <= 1'b1;
      o_data_bus_lines         <= `DMABI_BYTE_RST;
      o_data_bus_lines_oe      <= 1'b0;
      o_io_read_strobe_n       <= 1'b1;
      o_io_read_strobe_n_oe    <= 1'b0;
      o_io_write_strobe_n      <= 1'b1;
      o_io_write_strobe_n_oe   <= 1'b0;
      o_end_of_process_n       <= 1'b1;
      o_end_of_process_n_oe    <= 1'b0;
      o_low_address_nibble     <= 4'h0;
      o_low_address_nibble_oe  <= 1'b0;
      o_high_address_nibble    <= 4'h0;
      o_high_address_nibble_oe <= 1'b0;
      o_mem_data               <= `DMABI_BYTE_RST;
      o_mem_data_valid         <= 1'b0;
      o_busy                   <= 1'b0;
    end else if (i_ce) begin
      state_ff         <= nxt_state;
      o_mem_data       <= fifo_out_data;
      o_mem_data_valid <= fifo_out_valid;
      o_busy           <= (nxt_state != ST_IDLE);
      // One write per strobe low phase
      wr_seen_ff <= wr_stb;
      if (wr_stb && !wr_seen_ff) begin
        case (i_low_address_nibble)
          `DMABI_REG_CMD:  cmd_ff  <= i_data_bus_lines;
          `DMABI_REG_REQ:  req_ff[i_data_bus_lines[1:0]] <=
                             i_data_bus_lines[`DMABI_REQ_SET];
          `DMABI_REG_MASK: mask_ff <= i_data_bus_lines[3:0];
          `DMABI_REG_MODE: dir_ff[i_data_bus_lines[1:0]] <=
                             i_data_bus_lines[`DMABI_MODE_DIR];
          default: begin
            if (!i_low_address_nibble[3]) begin
              if (i_low_address_nibble[0])
                count_ff[i_low_address_nibble[2:1]] <=
                  {8'h00, i_data_bus_lines};
              else
                addr_ff[i_low_address_nibble[2:1]] <=
                  {8'h00, i_data_bus_lines};
            end
          end
        endcase
      end
      // Reading STATUS clears its low nibble, as a side effect of the access
      rd_seen_ff <= idle_sel && !ior_s;
      o_data_bus_lines_oe <= idle_sel && !ior_s;
      if (idle_sel && !ior_s) begin
        o_data_bus_lines <= rd_data;
        if (!rd_seen_ff && i_low_address_nibble == `DMABI_REG_STATUS)
          status_ff <= {req_s, 4'h0};
      end else begin
        status_ff[7:4] <= req_s;
      end
      // Hold request follows pending work until service ends
      o_bus_hold_request <= (nxt_state == ST_HOLD) ||
                            (nxt_state == ST_ADDR) ||
                            (nxt_state == ST_XFER) ||
                            (nxt_state == ST_WAIT);
      if (state_ff == ST_HOLD && nxt_state == ST_ADDR) begin
        chan_ff     <= nxt_chan;
        cur_addr_ff <= addr_ff[nxt_chan];
      end
      // Address phase: high byte on data bus with strobe
      if (state_ff != ST_IDLE && nxt_state == ST_ADDR) begin
        o_upper_address_gate     <= 1'b1;
        o_upper_address_strobe   <= 1'b1;
        o_data_bus_lines         <= nxt_addr[15:8];
        o_data_bus_lines_oe      <= 1'b1;
        o_low_address_nibble     <= nxt_addr[3:0];
        o_high_address_nibble    <= nxt_addr[7:4];
        o_low_address_nibble_oe  <= 1'b1;
        o_high_address_nibble_oe <= 1'b1;
        o_io_read_strobe_n_oe    <= 1'b1;
        o_io_write_strobe_n_oe   <= 1'b1;
      end else begin
        o_upper_address_strobe <= 1'b0;
      end
      // Transfer phase strobes; held through wait states
      if (nxt_state == ST_XFER || nxt_state == ST_WAIT) begin
        o_data_bus_lines_oe     <= 1'b0;
        o_channel_grant_n       <= ~(4'h1 << chan_ff);
        o_memory_read_strobe_n  <= ~(is_m2m | ~cur_dir);
        o_memory_write_strobe_n <= ~(is_m2m | cur_dir);
        o_io_read_strobe_n      <= ~(~is_m2m & cur_dir);
        o_io_write_strobe_n     <= ~(~is_m2m & ~cur_dir);
      end else begin
        o_memory_read_strobe_n  <= 1'b1;
        o_memory_write_strobe_n <= 1'b1;
        o_io_read_strobe_n      <= 1'b1;
        o_io_write_strobe_n     <= 1'b1;
        o_channel_grant_n       <= 4'hF;
      end
      // Advance address and count when a byte completes
      if (state_ff == ST_XFER && nxt_state != ST_WAIT) begin
        temp_ff     <= i_data_bus_lines;
        cur_addr_ff <= cur_addr_ff + 16'h0001;
        count_ff[chan_ff] <= count_ff[chan_ff] - 16'h0001;
        if (nxt_state == ST_DONE) begin
          status_ff[chan_ff] <= 1'b1;
          req_ff[chan_ff]    <= 1'b0;
        end
      end
      // Release everything once service is over
      if (nxt_state == ST_DONE || nxt_state == ST_IDLE) begin
        o_upper_address_gate     <= 1'b0;
        o_low_address_nibble_oe  <= 1'b0;
        o_high_address_nibble_oe <= 1'b0;
        o_io_read_strobe_n_oe    <= 1'b0;
        o_io_write_strobe_n_oe   <= 1'b0;
        if (state_ff != ST_IDLE) o_data_bus_lines_oe <= 1'b0;
      end
      if (state_ff == ST_DONE) begin
        addr_ff[chan_ff] <= cur_addr_ff;
      end
    end
  end
endmodule // dmabi_core

/* tb/dmabi_core_monitor.sv */
module dmabi_core_monitor (
  input wire       i_clk_sys,
  input wire       i_rst,
  input wire       i_chip_select_n,
  input wire       i_io_read_strobe_n,
  input wire       i_bus_hold_grant,
  input wire       o_bus_hold_request,
  input wire [3:0] o_channel_grant_n,
  input wire       o_upper_address_gate,
  input wire       o_upper_address_strobe,
  input wire       o_memory_read_strobe_n,
  input wire       o_memory_write_strobe_n,
  input wire       o_data_bus_lines_oe,
  input wire       o_io_read_strobe_n,
  input wire       o_io_read_strobe_n_oe,
  input wire       o_io_write_strobe_n,
  input wire       o_io_write_strobe_n_oe,
  input wire       o_high_address_nibble_oe,
  input wire       o_busy
);
  // ----------------------------------------------------------
  // Checks at the pins
  // ----------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // Combined CPU read select, so one signal can be looked back at
  wire cpu_rd_n = i_chip_select_n | i_io_read_strobe_n;
  // Address byte strobe: one high cycle, then low
  sequence s_addr_pulse;
    o_upper_address_strobe ##1 !o_upper_address_strobe;
  endsequence
  chk_strobe_pulse: assert property (
    o_upper_address_strobe |-> s_addr_pulse)
    else $error("address strobe longer than one cycle");
  chk_strobe_drives_bus: assert property (
    o_upper_address_strobe |-> o_data_bus_lines_oe && o_upper_address_gate)
    else $error("address strobe without bus drive");
  chk_gate_after_grant: assert property (
    $rose(o_upper_address_gate) |-> $past(i_bus_hold_grant, 2))
    else $error("address gate before hold grant");
  chk_memory_read_strobe_n_in_service: assert property (
    !o_memory_read_strobe_n |-> o_high_address_nibble_oe && o_bus_hold_request)
    else $error("memory read strobe outside service");
  chk_memory_write_strobe_n_in_service: assert property (
    !o_memory_write_strobe_n |-> o_high_address_nibble_oe && o_bus_hold_request)
    else $error("memory write strobe outside service");
  chk_ior_write_xfer: assert property (
    o_io_read_strobe_n_oe && !o_io_read_strobe_n |-> o_memory_read_strobe_n)
    else $error("io read with memory read");
  chk_iow_read_xfer: assert property (
    o_io_write_strobe_n_oe && !o_io_write_strobe_n |-> o_memory_write_strobe_n)
    else $error("io write with memory write");
  chk_one_grant: assert property (
    $onehot0(~o_channel_grant_n))
    else $error("more than one channel granted");
  chk_idle_quiet: assert property (
    !o_busy |-> o_channel_grant_n == 4'hF && !o_high_address_nibble_oe)
    else $error("idle but still driving");
  chk_read_answer: assert property (
    $rose(o_data_bus_lines_oe) && !o_busy |-> $past(cpu_rd_n, 2) == 1'b0)
    else $error("data bus driven without selected read");
  chk_hold_drop: assert property (
    $fell(o_bus_hold_request) |-> !o_upper_address_gate)
    else $error("hold dropped with bus still gated");
endmodule // dmabi_core_monitor

bind dmabi_core dmabi_core_monitor i_dmabi_core_monitor (.*);

/* tb/dmabi_cpu_model.sv */
module dmabi_cpu_model (
  input  wire        i_clk_sys,
  input  wire        i_rst,
  input  wire        i_hold_req,
  input  wire  [3:0] i_grant_n,
  input  wire  [3:0] i_arm,
  input  wire  [3:0] i_drop,
  input  wire        i_mem_strobe_n,
  input  wire        i_slow,
  output logic       o_hold_grant,
  output logic [3:0] o_request,
  output wire        o_ready_n,
  output logic [7:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] hold_dly;
  logic [2:0] wait_cnt;
  // ----------------------------------------------------------
  // CPU, peripherals and slow memory
  // ----------------------------------------------------------
  // Slow mode holds ready off three cycles per strobe
  assign o_ready_n = (wait_cnt != 3'h0);
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      hold_dly     <= 2'h0;
      o_hold_grant <= 1'b0;
      o_request    <= 4'h0;
      wait_cnt     <= 3'h0;
      o_data       <= 8'h5A;
    end else begin
      // Grant three cycles late, buses let go meanwhile
      hold_dly     <= {hold_dly[0], i_hold_req};
      o_hold_grant <= hold_dly[1] & i_hold_req;
      // Request held high until its grant goes low
      o_request <= (o_request | i_arm) & i_grant_n & ~i_drop;
      if (i_mem_strobe_n)
        wait_cnt <= i_slow ? 3'h3 : 3'h0;
      else if (wait_cnt != 3'h0)
        wait_cnt <= wait_cnt - 3'h1;
      // Bus byte changes every cycle so stale values never match
      o_data <= o_data + 8'h3B;
    end
  end
endmodule // dmabi_cpu_model

/* tb/testbench.sv */
`include "dmabi_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst, cs_n, ior_n, iow_n, eop_n, drv, slow, clr;
  logic [3:0] addr, arm, drop, first_g;
  logic [7:0] data, q, d;
  logic s_memory_read_strobe_n, s_memory_write_strobe_n, s_iow, s_ior;
  logic [15:0] base_a [4];
  logic [3:0] prev_g;
  int done_n [4] = '{default: 0};
  int seed, checks, fail_count;
  wire hold_req, gate, stb, memory_read_strobe_n_n, memory_write_strobe_n_n, db_oe, ior_o, ior_oe, iow_o;
  wire iow_oe, eop_o, eop_oe, lo_oe, hi_oe, busy, hold_gnt, ready_n;
  wire [3:0] grant_n, req, lo_o, hi_o;
  wire [7:0] db_o, mod_data;
  // Shared wires: whoever enables wins, otherwise the other party
  wire [7:0] db_w = db_oe ? db_o : (drv ? data : mod_data);
  wire ior_w = ior_oe ? ior_o : ior_n;
  wire iow_w = iow_oe ? iow_o : iow_n;
  wire eop_w = eop_oe ? eop_o : eop_n;
  wire [3:0] lo_w = lo_oe ? lo_o : addr;
  dmabi_core i_dmabi_core (.i_clk_sys(clk_sys), .i_rst(rst), .i_ce(1'b1),
    .i_chip_select_n(cs_n), .i_ready_n(ready_n), .i_bus_hold_grant(hold_gnt),
    .i_channel_request(req), .o_bus_hold_request(hold_req),
    .o_channel_grant_n(grant_n), .o_upper_address_gate(gate),
    .o_upper_address_strobe(stb), .o_memory_read_strobe_n(memory_read_strobe_n_n),
    .o_memory_write_strobe_n(memory_write_strobe_n_n), .i_data_bus_lines(db_w),
    .o_data_bus_lines(db_o), .o_data_bus_lines_oe(db_oe),
    .i_io_read_strobe_n(ior_w), .o_io_read_strobe_n(ior_o),
    .o_io_read_strobe_n_oe(ior_oe), .i_io_write_strobe_n(iow_w),
    .o_io_write_strobe_n(iow_o), .o_io_write_strobe_n_oe(iow_oe),
    .i_end_of_process_n(eop_w), .o_end_of_process_n(eop_o),
    .o_end_of_process_n_oe(eop_oe), .i_low_address_nibble(lo_w),
    .o_low_address_nibble(lo_o), .o_low_address_nibble_oe(lo_oe),
    .o_high_address_nibble(hi_o), .o_high_address_nibble_oe(hi_oe),
    .o_mem_data(), .o_mem_data_valid(), .o_busy(busy));
  dmabi_cpu_model i_dmabi_cpu_model (.i_clk_sys(clk_sys), .i_rst(rst),
    .i_hold_req(hold_req), .i_grant_n(grant_n), .i_arm(arm), .i_drop(drop),
    .i_mem_strobe_n(memory_read_strobe_n_n & memory_write_strobe_n_n), .i_slow(slow), .o_hold_grant(hold_gnt),
    .o_request(req), .o_ready_n(ready_n), .o_data(mod_data));
  // ----------------------------------------------------------
  // Clock, watchdog and activity flags
  // ----------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (90000) @(posedge clk_sys);
    fail_count++;
    report_and_stop();
  end
  always @(posedge clk_sys) begin
    if (clr) begin
      {s_memory_read_strobe_n, s_memory_write_strobe_n, s_iow, s_ior} <= 4'h0;
      first_g <= 4'hF;
    end else begin
      s_memory_read_strobe_n <= s_memory_read_strobe_n | !memory_read_strobe_n_n;
      s_memory_write_strobe_n <= s_memory_write_strobe_n | !memory_write_strobe_n_n;
      s_iow  <= s_iow | (iow_oe & !iow_o);
      s_ior  <= s_ior | (ior_oe & !ior_o);
      if (first_g === 4'hF && grant_n !== 4'hF) first_g <= grant_n;
    end
  end
  // Each grant fall opens one byte; address is base plus bytes done
  always @(posedge clk_sys) begin
    prev_g <= grant_n;
    for (int c = 0; c < 4; c++) begin
      automatic logic [15:0] ea = base_a[c] + 16'(done_n[c]);
      if (prev_g === 4'hF && grant_n === ~(4'h1 << c)) begin
        check("addr high", db_o, ea[15:8]);
        check("addr low", {hi_o, lo_o}, ea[7:0]);
        check("addr gate", {5'h0, gate, hi_oe, lo_oe}, 8'h07);
        done_n[c] <= done_n[c] + 1;
      end
    end
  end
  // ----------------------------------------------------------
  // Tasks and expectation functions
  // ----------------------------------------------------------
  function automatic logic [3:0] exp_grant(input logic [3:0] r);
    exp_grant = 4'hF;
    for (int k = 3; k >= 0; k--) if (r[k]) exp_grant = ~(4'h1 << k);
  endfunction
  task automatic check(input string what, input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Held long enough for the pin synchronisers, one access per low phase
  task automatic cpu(input logic wr, input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    cs_n <= 1'b0;
    addr <= a;
    data <= v;
    drv <= wr;
    iow_n <= !wr;
    ior_n <= wr;
    repeat (8) @(posedge clk_sys);
    q = db_w;
    {cs_n, iow_n, ior_n, drv} <= 4'hE;
    repeat (5) @(posedge clk_sys);
  endtask
  task automatic wait_busy(input logic lvl, input int lim);
    for (int n = 0; n < lim && busy !== lvl; n++) @(posedge clk_sys);
    if (busy !== lvl) begin
      fail_count++;
      $display("wrong value busy expected %b seen %b", lvl, busy);
      report_and_stop();
    end
  endtask
  task automatic run_dma(input logic [3:0] chans);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    arm <= chans;
    @(posedge clk_sys);
    arm <= 4'h0;
    wait_busy(1'b1, 200);
  endtask
  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    seed = 89;
    {rst, cs_n, ior_n, iow_n, eop_n, drv, slow, clr} = 8'hFC;
    {addr, arm, drop, data} = 20'h0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    check("grant", {4'h0, grant_n}, 8'h0F);
    check("drive", {hold_req, db_oe, hi_oe, lo_oe, gate}, 8'h00);
    check("eop drive", {6'h0, eop_oe, eop_o}, 8'h01);
    cpu(1'b0, `DMABI_REG_TEMP, 8'h00);
    check("temp", q, `DMABI_BYTE_RST);
    cpu(1'b0, `DMABI_REG_STATUS, 8'h00);
    check("status", q, `DMABI_STAT_RST);
    for (int k = 0; k < 4; k++) begin
      d = $random(seed);
      cpu(1'b1, 4'(2 * k), d);
      cpu(1'b0, 4'(2 * k), 8'h00);
      check("address reg", q, d);
      base_a[k] = {8'h00, d};
    end
    // Reset mask blocks a request, then the disable bit does
    run_req_blocked(4'h1);
    cpu(1'b1, `DMABI_REG_MASK, 8'h00);
    cpu(1'b1, `DMABI_REG_CMD, 8'h04);
    run_req_blocked(4'h2);
    cpu(1'b1, `DMABI_REG_CMD, `DMABI_CMD_RST);
    // Two channels at once, read transfers, fast memory
    cpu(1'b1, `DMABI_REG_COUNT0, 8'h00);
    cpu(1'b1, `DMABI_REG_COUNT2, 8'h00);
    run_dma(4'h5);
    wait_busy(1'b0, 2000);
    check("first grant", {4'h0, first_g}, {4'h0, exp_grant(4'h5)});
    check("read xfer", {s_memory_read_strobe_n, s_iow, s_memory_write_strobe_n}, 8'h06);
    wait_busy(1'b1, 200);
    wait_busy(1'b0, 2000);
    // Write transfer on slow memory
    slow <= 1'b1;
    cpu(1'b1, `DMABI_REG_MODE, 8'h04);
    // Count wrapped after the last service; one byte again
    cpu(1'b1, `DMABI_REG_COUNT0, 8'h00);
    run_dma(4'h1);
    wait_busy(1'b0, 2000);
    check("write xfer", {s_memory_write_strobe_n, s_ior, s_memory_read_strobe_n}, 8'h06);
    // Long count cut short from outside
    cpu(1'b1, `DMABI_REG_COUNT0, 8'hFF);
    d = $random(seed);
    slow <= d[0];
    run_dma(4'h1);
    repeat (20) @(posedge clk_sys); // Let several bytes go first
    eop_n <= 1'b0;
    wait_busy(1'b0, 200);
    eop_n <= 1'b1;
    check("hold after", {7'h0, hold_req}, 8'h00);
    report_and_stop();
  end
  task automatic run_req_blocked(input logic [3:0] chans);
    arm <= chans;
    @(posedge clk_sys);
    arm <= 4'h0;
    repeat (30) @(posedge clk_sys);
    check("hold blocked", {7'h0, hold_req}, 8'h00);
    drop <= 4'hF;
    @(posedge clk_sys);
    drop <= 4'h0;
  endtask
endmodule // testbench
